// ==== svc_ctrl.sv ====
/*
 Host controller driving a shadowed 8K x 8 static RAM over its pins:
 single reads and writes, and six-read save or load sequences.
 Assumes the supply monitor inputs are asynchronous levels and the user
 request port is on clk_sys. The device itself lies outside this block.
*/
// Behaviour
// - Address stable across whole write cycle
// - Gate kept high throughout every write
// - Save sequence: six reads ending 0F0F
// - Load sequence: six reads ending 0F0E
// - Gate stays high through all six
`timescale 1ns/10ps
module svc_ctrl #(
    parameter int NV_SAVE_CYCLES = svc_pkg::NV_SAVE_CYC,
    parameter int PU_LOAD_CYCLES = svc_pkg::PU_LOAD_CYC
) (
    input  wire logic                       clk_sys,
    input  wire logic                       rst,
    input  wire logic                       req_valid,
    input  wire svc_pkg::svc_cmd_type       req_cmd,
    input  wire logic [svc_pkg::ADDR_W-1:0] req_addr,
    input  wire logic [svc_pkg::DATA_W-1:0] req_wdata,
    output logic                            req_ready,
    output logic                            rsp_valid,
    output logic [svc_pkg::DATA_W-1:0]      rsp_rdata,
    output logic                            rsp_refused,
    input  wire logic                       supply_low,
    input  wire logic                       supply_reset,
    output logic                            nv_busy,
    output logic                            nv_dirty,
    output logic [svc_pkg::ADDR_W-1:0]      location_pins,
    output logic                            sel_n,
    output logic                            wr_n,
    output logic                            gate_n,
    input  wire logic [svc_pkg::DATA_W-1:0] bidir_data_pins_in,
    output logic [svc_pkg::DATA_W-1:0]      bidir_data_pins_out,
    output logic                            bidir_data_pins_oe
);
    import svc_pkg::*;

    svc_state_type     state_q;
    svc_cmd_type       cmd_q;
    logic [7:0]        phase_q;
    logic [2:0]        step_q;
    logic [DATA_W-1:0] din_s1_q;
    logic [DATA_W-1:0] din_s2_q;
    logic [1:0]        low_sync_q;
    logic [1:0]        rst_sync_q;
    logic              low_prev_q;
    logic              load_pend_q;
    logic              timer_load;
    logic [CNT_W-1:0]  timer_count;
    logic              timer_done;
    logic              supply_low_s;
    logic              is_seq;
    logic              last_step;

    assign supply_low_s = low_sync_q[1];
    assign is_seq = cmd_q[1];
    assign last_step = (step_q == 3'(SEQ_LEN - 1));

    // Pins and supply monitor pass two flops before use
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            din_s1_q <= '0;
            din_s2_q <= '0;
            low_sync_q <= 2'b11;
            rst_sync_q <= 2'b11;
        end else begin
            din_s1_q <= bidir_data_pins_in;
            din_s2_q <= din_s1_q;
            low_sync_q <= {low_sync_q[0], supply_low};
            rst_sync_q <= {rst_sync_q[0], supply_reset};
        end
    end

    // Pending load latched at reset and on deep supply drop
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            load_pend_q <= 1'b1;
        end else if (rst_sync_q[1]) begin
            load_pend_q <= 1'b1;
        end else if (load_pend_q && !supply_low_s) begin
            load_pend_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            low_prev_q <= 1'b1;
        end else begin
            low_prev_q <= supply_low_s;
        end
    end

    // Tracks device's dirty flag: automatic save only follows a write
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            nv_dirty <= 1'b0;
        end else if (state_q == SVC_HOLD && phase_q == 8'h00
                     && cmd_q == SVC_CMD_WRITE) begin
            nv_dirty <= 1'b1;
        end else if (timer_load) begin
            nv_dirty <= 1'b0;
        end
    end

    // Busy timer loads: sequence end, power-up load, supply loss save
    always_comb begin
        timer_load = 1'b0;
        timer_count = '0;
        if (state_q == SVC_HOLD && phase_q == 8'h00 && is_seq && last_step)
        begin
            timer_load = 1'b1;
            timer_count = (cmd_q == SVC_CMD_SAVE)
                ? CNT_W'(NV_SAVE_CYCLES + SEQ_OFF_CYC)
                : CNT_W'(NV_LOAD_CYC + SEQ_OFF_CYC);
        end else if (load_pend_q && !supply_low_s) begin
            timer_load = 1'b1;
            timer_count = CNT_W'(PU_LOAD_CYCLES);
        end else if (supply_low_s && !low_prev_q && nv_dirty) begin
            timer_load = 1'b1;
            timer_count = CNT_W'(NV_SAVE_CYCLES);
        end
    end

    svc_wait_timer u_timer (
        .clk_sys (clk_sys),
        .rst     (rst),
        .load    (timer_load),
        .count   (timer_count),
        .done    (timer_done)
    );

    // Pin cycle sequencer
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_q <= SVC_IDLE;
            cmd_q <= SVC_CMD_READ;
            phase_q <= 8'h00;
            step_q <= 3'd0;
            location_pins <= '0;
            sel_n <= 1'b1;
            wr_n <= 1'b1;
            gate_n <= 1'b1;
            bidir_data_pins_out <= '0;
            bidir_data_pins_oe <= 1'b0;
            req_ready <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_rdata <= '0;
            rsp_refused <= 1'b0;
            nv_busy <= 1'b1;
        end else begin
            rsp_valid <= 1'b0;
            rsp_refused <= 1'b0;
            req_ready <= 1'b0;
            nv_busy <= !timer_done || load_pend_q || supply_low_s;
            unique case (state_q)
                SVC_IDLE: begin
                    if (req_valid && !req_ready && supply_low_s
                        && req_cmd == SVC_CMD_SAVE) begin
                        // A save is refused while supply is low so the user never stalls on it
                        req_ready <= 1'b1;
                        rsp_valid <= 1'b1;
                        rsp_refused <= 1'b1;
                    end else if (!timer_done || load_pend_q || supply_low_s) begin
                        nv_busy <= 1'b1; // Pins idle while device busy
                    end else if (req_valid && !req_ready) begin
                        req_ready <= 1'b1;
                        cmd_q <= req_cmd;
                        step_q <= 3'd0;
                        state_q <= SVC_SETUP;
                        location_pins <= req_cmd[1]
                            ? svc_seq_addr(3'd0, 1'b0)
                            : req_addr;
                        bidir_data_pins_out <= req_wdata;
                        bidir_data_pins_oe <= (req_cmd == SVC_CMD_WRITE);
                        phase_q <= 8'(SETUP_CYC - 1);
                    end
                end
                SVC_SETUP: begin
                    if (phase_q != 8'h00) begin
                        phase_q <= phase_q - 8'h01;
                    end else begin
                        sel_n <= 1'b0;
                        wr_n <= !(cmd_q == SVC_CMD_WRITE);
                        gate_n <= (cmd_q != SVC_CMD_READ);
                        phase_q <= 8'(STROBE_CYC - 1);
                        state_q <= SVC_STROBE;
                    end
                end
                SVC_STROBE: begin
                    if (phase_q != 8'h00) begin
                        phase_q <= phase_q - 8'h01;
                    end else begin
                        sel_n <= 1'b1; // Select, write and gate rise together, ends cycle
                        wr_n <= 1'b1;
                        gate_n <= 1'b1;
                        rsp_rdata <= din_s2_q;
                        phase_q <= 8'(HOLD_CYC - 1);
                        state_q <= SVC_HOLD;
                    end
                end
                SVC_HOLD: begin
                    if (phase_q != 8'h00) begin
                        phase_q <= phase_q - 8'h01;
                    end else begin
                        bidir_data_pins_oe <= 1'b0; // Data held past end
                        if (is_seq && !last_step) begin
                            step_q <= step_q + 3'd1;  // back to back
                            location_pins <= svc_seq_addr(step_q + 3'd1,
                                cmd_q == SVC_CMD_LOAD);
                            phase_q <= 8'(SETUP_CYC - 1);
                            state_q <= SVC_SETUP;
                        end else begin
                            rsp_valid <= 1'b1;
                            state_q <= is_seq ? SVC_WAIT : SVC_IDLE;
                        end
                    end
                end
                SVC_WAIT: begin
                    if (timer_done) begin
                        state_q <= SVC_IDLE;
                    end
                end
                default: state_q <= SVC_IDLE;
            endcase
        end
    end
endmodule : svc_ctrl

// ==== svc_pkg.sv ====
/*
 Constants for the host-side controller of a shadowed 8K x 8 static RAM.
 Assumes a 200 MHz system clock; all pin timing is counted in its cycles.
*/
package svc_pkg;
    localparam int          CLK_MHZ          = 200;
    localparam int          ADDR_W           = 13;
    localparam int          DATA_W           = 8;
    localparam int          DEPTH            = 8192;
    // Pin cycle phase lengths in ns, rounded up to whole cycles
    localparam int          SETUP_NS         = 10;
    localparam int          STROBE_NS        = 45;
    localparam int          HOLD_NS          = 10;
    localparam int          SETUP_CYC        = (SETUP_NS * CLK_MHZ + 999) / 1000;
    localparam int          STROBE_CYC       = (STROBE_NS * CLK_MHZ + 999) / 1000;
    localparam int          HOLD_CYC         = (HOLD_NS * CLK_MHZ + 999) / 1000;
    // Busy waits after a sequence or power-up, in their own units
    localparam int          SEQ_OFF_NS       = 650;
    localparam int          NV_LOAD_US       = 20;
    localparam int          NV_SAVE_MS       = 10;
    localparam int          PU_LOAD_US       = 550;
    localparam int          SEQ_OFF_CYC      = (SEQ_OFF_NS * CLK_MHZ + 999) / 1000;
    localparam int          NV_LOAD_CYC      = NV_LOAD_US * CLK_MHZ;
    localparam int          NV_SAVE_CYC      = NV_SAVE_MS * 1000 * CLK_MHZ;
    localparam int          PU_LOAD_CYC      = PU_LOAD_US * CLK_MHZ;
    localparam int          CNT_W            = 22;
    localparam int          SEQ_LEN          = 6;
    localparam logic [12:0] SEQ_A0           = 13'h0000;
    localparam logic [12:0] SEQ_A1           = 13'h1555;
    localparam logic [12:0] SEQ_A2           = 13'h0AAA;
    localparam logic [12:0] SEQ_A3           = 13'h1FFF;
    localparam logic [12:0] SEQ_A4           = 13'h10F0;
    localparam logic [12:0] SEQ_SAVE_LAST    = 13'h0F0F;
    localparam logic [12:0] SEQ_LOAD_LAST    = 13'h0F0E;

    typedef enum logic [1:0] {
        SVC_CMD_READ = 2'b00,
        SVC_CMD_WRITE = 2'b01,
        SVC_CMD_SAVE = 2'b10,
        SVC_CMD_LOAD = 2'b11
    } svc_cmd_type;

    typedef enum logic [2:0] {
        SVC_IDLE   = 3'b000,
        SVC_SETUP  = 3'b001,
        SVC_STROBE = 3'b010,
        SVC_HOLD   = 3'b011,
        SVC_WAIT   = 3'b100
    } svc_state_type;

    function automatic logic [12:0] svc_seq_addr(input logic [2:0] step,
                                                 input logic       load);
        case (step)
            3'd0:    svc_seq_addr = SEQ_A0;
            3'd1:    svc_seq_addr = SEQ_A1;
            3'd2:    svc_seq_addr = SEQ_A2;
            3'd3:    svc_seq_addr = SEQ_A3;
            3'd4:    svc_seq_addr = SEQ_A4;
            default: svc_seq_addr = load ? SEQ_LOAD_LAST : SEQ_SAVE_LAST;
        endcase
    endfunction : svc_seq_addr
endpackage : svc_pkg

// ==== svc_wait_timer.sv ====
/*
 Down-counting busy timer for nonvolatile operations.
 Assumes load is a one-cycle pulse from the same clock.
*/
`timescale 1ns/10ps
module svc_wait_timer (
    input  wire logic                       clk_sys,
    input  wire logic                       rst,
    input  wire logic                       load,
    input  wire logic [svc_pkg::CNT_W-1:0]  count,
    output logic                            done
);
    import svc_pkg::*;
    logic [CNT_W-1:0] cnt_q;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cnt_q <= '0;
        end else if (load) begin
            cnt_q <= count;
        end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - CNT_W'(1);
        end
    end

    assign done = (cnt_q == '0) && !load;
endmodule : svc_wait_timer

// ==== svc_ctrl_properties.sv ====
/*
 Pin and user-port assertions for svc_ctrl.
 Assumes it is bound into svc_ctrl, clocked by clk_sys, reset by rst.
*/
`timescale 1ns/10ps
module svc_ctrl_properties
    import svc_pkg::*;
(
    input wire logic                       clk_sys,
    input wire logic                       rst,
    input wire svc_pkg::svc_cmd_type       req_cmd,
    input wire logic                       req_ready,
    input wire logic                       rsp_valid,
    input wire logic                       rsp_refused,
    input wire logic                       nv_busy,
    input wire logic [svc_pkg::ADDR_W-1:0] location_pins,
    input wire logic                       sel_n,
    input wire logic                       wr_n,
    input wire logic                       gate_n,
    input wire logic [svc_pkg::DATA_W-1:0] bidir_data_pins_out,
    input wire logic                       bidir_data_pins_oe
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    wr_gate_a: assert property (!wr_n |-> gate_n)
        else $error("gate low during write");
    drv_gate_a: assert property (bidir_data_pins_oe |-> gate_n)
        else $error("host drives data with gate low");
    addr_hold_a: assert property (!sel_n && $past(!sel_n) |->
        $stable(location_pins)) else $error("address moved in cycle");
    wdata_hold_a: assert property (!wr_n |=> wr_n ||
        $stable(bidir_data_pins_out)) else $error("write data moved");
    busy_park_a: assert property (nv_busy |-> sel_n &&
        !bidir_data_pins_oe) else $error("pins active while busy");
    ready_pulse_a: assert property (req_ready |=> !req_ready)
        else $error("ready longer than one cycle");
    refuse_save_a: assert property (rsp_refused |-> rsp_valid &&
        req_cmd == SVC_CMD_SAVE) else $error("bad refusal");
    read_lat_a: assert property (req_ready && req_cmd == SVC_CMD_READ
        |-> ##13 rsp_valid) else $error("read answer late");
    strobe_len_a: assert property ($fell(sel_n) |-> (!sel_n) [*8])
        else $error("select strobe too short");
endmodule : svc_ctrl_properties

bind svc_ctrl svc_ctrl_properties u_props (
    .clk_sys(clk_sys), .rst(rst), .req_cmd(req_cmd),
    .req_ready(req_ready), .rsp_valid(rsp_valid),
    .rsp_refused(rsp_refused), .nv_busy(nv_busy),
    .location_pins(location_pins), .sel_n(sel_n), .wr_n(wr_n),
    .gate_n(gate_n), .bidir_data_pins_out(bidir_data_pins_out),
    .bidir_data_pins_oe(bidir_data_pins_oe)
);

// ==== svc_dev_model.sv ====
/*
 Behavioural shadowed 8K x 8 static RAM facing svc_ctrl.
 Assumes pin levels from the host and supply levels from the bench.
*/
`timescale 1ns/10ps
module svc_dev_model #(
    parameter int SAVE_NS = 1000,
    parameter int LOAD_NS = 20000
) (
    input  wire logic [12:0] location_pins,
    input  wire logic        sel_n,
    input  wire logic        wr_n,
    input  wire logic        gate_n,
    input  wire logic        supply_low,
    input  wire logic        supply_reset,
    input  wire logic [7:0]  host_d,
    input  wire logic        host_oe,
    output logic      [7:0]  dq
);
    logic [7:0]  mem [8192];
    logic [7:0]  nv [8192];
    logic [12:0] seq [5] = '{13'h0000, 13'h1555, 13'h0AAA, 13'h1FFF,
                             13'h10F0};
    logic [2:0]  step = 3'h0;
    logic        wrote = 1'b0;
    logic        busy = 1'b0;
    logic        dirty = 1'b0;
    logic        pend = 1'b1;
    logic        drv;
    assign drv = !sel_n && !gate_n && wr_n && !busy;
    // Released bus shows the inverse, so a stale copy never passes
    assign dq = host_oe ? host_d : drv ? mem[location_pins]
                                       : ~mem[location_pins];
    initial for (int i = 0; i < 8192; i++) nv[i] = i[7:0] ^ 8'hA5;
    always @(posedge supply_reset) pend = 1'b1;
    always @(negedge supply_low) if (pend) begin
        mem = nv;
        pend = 1'b0;
    end
    always @(posedge supply_low) if (dirty) begin
        nv = mem;
        dirty = 1'b0;
    end
    always @(negedge wr_n or negedge sel_n) if (!wr_n && !sel_n) wrote = 1'b1;
    always @(posedge sel_n) begin
        if (busy) begin
            step = 3'h0;
        end else if (wrote) begin
            mem[location_pins] = host_d;
            dirty = 1'b1;
            step = 3'h0;
        end else if (step == 3'h5 && location_pins[12:1] == 12'h787) begin
            busy = 1'b1;
            step = 3'h0;
            dirty = 1'b0;
            if (location_pins[0] && !supply_low) nv = mem;
            if (!location_pins[0]) mem = nv;
            #(location_pins[0] ? SAVE_NS : LOAD_NS) busy = 1'b0;
        end else if (step < 3'h5 && location_pins == seq[step]) begin
            step = step + 3'h1;
        end else begin
            step = (location_pins == 13'h0000) ? 3'h1 : 3'h0;
        end
        wrote = 1'b0;
    end
endmodule : svc_dev_model

// ==== svc_tb.sv ====
/*
 Self-checking bench for svc_ctrl with a behavioural device model.
 Assumes short save and power-up counts for simulation.
*/
`timescale 1ns/10ps
module testbench;
    import svc_pkg::*;
    logic        clk_sys = 1'b0, rst = 1'b1, req_valid = 1'b0;
    svc_cmd_type req_cmd = SVC_CMD_READ;
    logic [12:0] req_addr = 13'h0000, location_pins;
    logic [7:0]  req_wdata = 8'h00, rsp_rdata, dout, din;
    logic        supply_low = 1'b1, supply_reset = 1'b0, refused_seen;
    logic        req_ready, rsp_valid, rsp_refused, nv_busy, nv_dirty;
    logic        sel_n, wr_n, gate_n, oe;
    int          fails = 0, comparisons = 0;
    svc_ctrl #(.NV_SAVE_CYCLES(200), .PU_LOAD_CYCLES(2000)) dut (
        .clk_sys(clk_sys), .rst(rst),
        .req_valid(req_valid), .req_cmd(req_cmd), .req_addr(req_addr),
        .req_wdata(req_wdata), .req_ready(req_ready), .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata), .rsp_refused(rsp_refused),
        .supply_low(supply_low), .supply_reset(supply_reset),
        .nv_busy(nv_busy), .nv_dirty(nv_dirty), .location_pins(location_pins),
        .sel_n(sel_n), .wr_n(wr_n), .gate_n(gate_n), .bidir_data_pins_in(din),
        .bidir_data_pins_out(dout), .bidir_data_pins_oe(oe));
    svc_dev_model dev (.location_pins(location_pins), .sel_n(sel_n),
        .wr_n(wr_n), .gate_n(gate_n), .supply_low(supply_low),
        .supply_reset(supply_reset), .host_d(dout), .host_oe(oe), .dq(din));
    initial forever #2.5 clk_sys = ~clk_sys;

    task test_done;
        if (fails == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : test_done
    task chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wt(ref logic s, input logic v, input int lim);
        int n = 0;
        while (s !== v) begin
            @(posedge clk_sys);
            n++;
            if (n > lim) begin
                fails++;
                $display("Error %0t: wait ran out", $time);
                test_done();
            end
        end
    endtask : wt
    task automatic rq(input svc_cmd_type c, input logic [12:0] a,
                      input logic [7:0] d);
        req_valid <= 1'b1;
        req_cmd <= c;
        req_addr <= a;
        req_wdata <= d;
        @(posedge clk_sys);
        wt(req_ready, 1'b1, 6000);
        req_valid <= 1'b0;
        wt(rsp_valid, 1'b1, 2000);
        refused_seen = rsp_refused;
        @(posedge clk_sys);
        // A refused save leaves the pins parked until supply returns
        if ((c == SVC_CMD_SAVE || c == SVC_CMD_LOAD) && !refused_seen)
            wt(nv_busy, 1'b0, 6000);
    endtask : rq

    task t_rw;
        rq(SVC_CMD_READ, 13'h0123, 8'h00);
        chk(rsp_rdata, 8'h23 ^ 8'hA5);
        rq(SVC_CMD_WRITE, 13'h1FFF, 8'h3C);
        chk(nv_dirty, 1'b1);
        rq(SVC_CMD_READ, 13'h1FFF, 8'h00);
        chk(rsp_rdata, 8'h3C);
    endtask : t_rw
    task t_save;
        rq(SVC_CMD_SAVE, 13'h0000, 8'h00);
        chk(dev.nv[13'h1FFF], 8'h3C);
        chk(nv_dirty, 1'b0);
        dev.nv[13'h1FFF] = 8'h00;
        rq(SVC_CMD_SAVE, 13'h0000, 8'h00);
        chk(dev.nv[13'h1FFF], 8'h3C);
    endtask : t_save
    task t_load;
        rq(SVC_CMD_WRITE, 13'h1FFF, 8'hC3);
        rq(SVC_CMD_LOAD, 13'h0000, 8'h00);
        rq(SVC_CMD_READ, 13'h1FFF, 8'h00);
        chk(rsp_rdata, 8'h3C);
    endtask : t_load
    task t_low;
        rq(SVC_CMD_WRITE, 13'h0005, 8'h5A);
        supply_low <= 1'b1;
        repeat (20) @(posedge clk_sys);
        chk(dev.nv[13'h0005], 8'h5A);
        rq(SVC_CMD_SAVE, 13'h0000, 8'h00);
        chk(refused_seen, 1'b1);
        supply_low <= 1'b0;
        repeat (400) @(posedge clk_sys);
        dev.nv[13'h0005] = 8'h11;
        supply_low <= 1'b1;
        repeat (400) @(posedge clk_sys);
        chk(dev.nv[13'h0005], 8'h11);
        supply_reset <= 1'b1;
        repeat (4) @(posedge clk_sys);
        supply_reset <= 1'b0;
        repeat (4) @(posedge clk_sys);
        supply_low <= 1'b0;
        repeat (10) @(posedge clk_sys);
        chk(nv_busy, 1'b1);
        rq(SVC_CMD_READ, 13'h0005, 8'h00);
        chk(rsp_rdata, 8'h11);
    endtask : t_low

    initial begin
        repeat (6) @(posedge clk_sys);
        rst <= 1'b0;
        supply_low <= 1'b0;
        @(posedge clk_sys);
        wt(nv_busy, 1'b0, 3000);
        t_rw();
        t_save();
        t_load();
        t_low();
        test_done();
    end
endmodule : testbench
